// ===== inc/acsc_params.svh
// Purpose: Constants of the converter start control block
// Assumes: core_clk at 25 MHz, special-function register port of the core
// Notes:   Offsets and field positions used by design and bench
//
// What this block does
// - Throughput never exceeds five hundred thousand conversions per second.
// - Conversion clock is the core clock divided by the config divider field plus one.
// - Three-bit source field in the control register picks one of eight starts.
// - In software mode, writing one to the busy bit starts a conversion.
// - Selected timer 0 to 5 overflow starts a conversion.
// - Rising edge on the external start pin starts a conversion when selected.
// - Busy bit reads one during conversion, zero once it finishes.
// - Busy falling sets the done flag and, if enabled, the interrupt request.
// - Result registers hold the converted value whenever done reads one.
// - Timers 2 to 5 trigger on low overflow in 8-bit, high in 16-bit.
// - Read/write threshold high byte at 0xC6, reset zero, all pages.
// - Read/write threshold low byte at 0xC5.
`ifndef ACSC_PARAMS_SVH
`define ACSC_PARAMS_SVH

// ==========================================================
// Register addresses
`define ACSC_ADDR_CTL     8'hE8
`define ACSC_ADDR_CFG     8'hBC
`define ACSC_ADDR_RES_LO  8'hBD
`define ACSC_ADDR_RES_HI  8'hBE
`define ACSC_ADDR_LTL     8'hC5
`define ACSC_ADDR_LTH     8'hC6

// ==========================================================
// Field positions
`define ACSC_CTL_DONE     5
`define ACSC_CTL_BUSY     4
`define ACSC_CTL_IRQEN    3
`define ACSC_CTL_SRC_HI   2
`define ACSC_CTL_SRC_LO   0
`define ACSC_CFG_DIV_HI   7
`define ACSC_CFG_DIV_LO   3

// ==========================================================
// Reset values and timing
`define ACSC_RST_BYTE     8'h00
`define ACSC_RST_CFG      8'hF8
`define ACSC_CLK_NS       40
`define ACSC_MIN_CONV_NS  2000
`define ACSC_MIN_CONV_CYC ((`ACSC_MIN_CONV_NS + `ACSC_CLK_NS - 1) / `ACSC_CLK_NS)

`endif

// ===== inc/acsc_pkg.sv
// Purpose: Types of the converter start control block
// Assumes: Nothing beyond the params header
// Notes:   Source codes follow the start list order
package acsc_pkg;

	typedef enum logic [2:0] {
		SRC_SW   = 3'h0,
		SRC_T0   = 3'h1,
		SRC_T2   = 3'h2,
		SRC_T1   = 3'h3,
		SRC_EXT  = 3'h4,
		SRC_T3   = 3'h5,
		SRC_T4   = 3'h6,
		SRC_T5   = 3'h7
	} acsc_src_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h1,
		ST_CONV = 2'h2
	} acsc_state_e;

endpackage

// ===== verilog/acsc_start_ctrl.sv
// Purpose: Start-source selection, busy tracking and done flag of the converter
// Assumes: Timer overflow inputs are one-cycle pulses on core_clk
// Notes:   Read data is registered, one cycle behind the address
`timescale 1ns/1ps
`default_nettype none
`include "acsc_params.svh"

module acsc_start_ctrl
	import acsc_pkg::*;
#(
	parameter int CONV_TICKS = 12,
	parameter int RES_W      = 10
) (
	input  wire logic             core_clk,
	input  wire logic             rst_b,
	input  wire logic [7:0]       sfrAddr,
	input  wire logic             sfrWrEn,
	input  wire logic [7:0]       sfrWrData,
	output logic      [7:0]       sfrRdData,
	input  wire logic [5:0]       timerOvfLow,
	input  wire logic [5:0]       timerOvfHigh,
	input  wire logic [5:0]       timer8BitMode,
	input  wire logic             extConvStart,
	input  wire logic [RES_W-1:0] sampleData,
	output logic                  convIrq
);

	// ==========================================================
	// Registers and state
	acsc_state_e state;
	acsc_src_e   startSrc;
	logic        doneFlag;
	logic        irqEn;
	logic [4:0]  divField;
	logic [7:0]  lthReg;
	logic [7:0]  ltlReg;
	logic [7:0]  resHi;
	logic [7:0]  resLo;
	logic [4:0]  divCnt;
	logic [7:0]  tickCnt;
	logic [15:0] convCycles;
	logic        extSync1;
	logic        extSync2;
	logic        extPrev;

	// ==========================================================
	// Decoding
	// Everything the function reads is an argument, so the assign re-evaluates on each pulse
	function automatic logic timerTrig(input int idx, input logic ovfLo, input logic ovfHi,
		input logic split8);
		// Timers 0 and 1 have a single overflow; the rest depend on split mode
		if (idx >= 2 && split8)
			return ovfLo;
		return ovfHi;
	endfunction

	wire logic [5:0] timerHit;
	for (genvar i = 0; i < $bits(timerHit); i++) begin : g_trig
		assign timerHit[i] = timerTrig(i, timerOvfLow[i], timerOvfHigh[i], timer8BitMode[i]);
	end

	wire logic busy    = (state == ST_CONV);
	wire logic wrCtl   = sfrWrEn && (sfrAddr == `ACSC_ADDR_CTL);
	wire logic wrCfg   = sfrWrEn && (sfrAddr == `ACSC_ADDR_CFG);
	wire logic wrLth   = sfrWrEn && (sfrAddr == `ACSC_ADDR_LTH);
	wire logic wrLtl   = sfrWrEn && (sfrAddr == `ACSC_ADDR_LTL);
	wire logic swStart = wrCtl && sfrWrData[`ACSC_CTL_BUSY] && (startSrc == SRC_SW);
	wire logic extEdge = extSync2 && !extPrev;
	wire logic [7:0] trigVec = {timerHit[5], timerHit[4], timerHit[3], extEdge,
		timerHit[1], timerHit[2], timerHit[0], swStart};
	wire logic startReq = trigVec[startSrc];
	wire logic divTick  = (divCnt == divField);
	wire logic finish   = busy && (tickCnt >= CONV_TICKS[7:0])
		&& (convCycles >= 16'(`ACSC_MIN_CONV_CYC - 1));
	wire logic [7:0] ctlRead = {2'h0, doneFlag, busy, irqEn, startSrc};
	wire logic [7:0] resFull = 8'(sampleData >> 8);

	logic [7:0] next_rdData;
	always_comb begin
		if (sfrAddr == `ACSC_ADDR_CTL)
			next_rdData = ctlRead;
		else if (sfrAddr == `ACSC_ADDR_CFG)
			next_rdData = {divField, 3'h0};
		else if (sfrAddr == `ACSC_ADDR_RES_LO)
			next_rdData = resLo;
		else if (sfrAddr == `ACSC_ADDR_RES_HI)
			next_rdData = resHi;
		else if (sfrAddr == `ACSC_ADDR_LTL)
			next_rdData = ltlReg;
		else if (sfrAddr == `ACSC_ADDR_LTH)
			next_rdData = lthReg;
		else
			next_rdData = `ACSC_RST_BYTE;
	end

	assign convIrq = doneFlag && irqEn;

	// ==========================================================
	// Pin synchroniser; only the second stage feeds the edge detector
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			extSync1 <= 1'b0;
			extSync2 <= 1'b0;
			extPrev  <= 1'b0;
		end else begin
			extSync1 <= extConvStart;
			extSync2 <= extSync1;
			extPrev  <= extSync2;
		end
	end

	// ==========================================================
	// Register file
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			startSrc  <= SRC_SW;
			irqEn     <= 1'b0;
			divField  <= 5'(`ACSC_RST_CFG >> `ACSC_CFG_DIV_LO);
			lthReg    <= `ACSC_RST_BYTE;
			ltlReg    <= `ACSC_RST_BYTE;
			sfrRdData <= `ACSC_RST_BYTE;
		end else begin
			sfrRdData <= next_rdData;
			if (wrCtl) begin
				startSrc <= acsc_src_e'(sfrWrData[`ACSC_CTL_SRC_HI:`ACSC_CTL_SRC_LO]);
				irqEn    <= sfrWrData[`ACSC_CTL_IRQEN];
			end
			if (wrCfg)
				divField <= sfrWrData[`ACSC_CFG_DIV_HI:`ACSC_CFG_DIV_LO];
			if (wrLth)
				lthReg <= sfrWrData;
			if (wrLtl)
				ltlReg <= sfrWrData;
		end
	end

	// ==========================================================
	// Done flag: a completion in the clearing cycle wins over the write
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			doneFlag <= 1'b0;
		else if (finish)
			doneFlag <= 1'b1;
		else if (wrCtl)
			doneFlag <= sfrWrData[`ACSC_CTL_DONE];
	end

	// ==========================================================
	// Conversion sequencer
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state      <= ST_IDLE;
			divCnt     <= 5'h0;
			tickCnt    <= 8'h0;
			convCycles <= 16'h0;
			resHi      <= `ACSC_RST_BYTE;
			resLo      <= `ACSC_RST_BYTE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (startReq) begin
						state      <= ST_CONV;
						divCnt     <= 5'h0;
						tickCnt    <= 8'h0;
						convCycles <= 16'h0;
					end
				end
				ST_CONV: begin
					// Further starts are simply not looked at here
					convCycles <= convCycles + 16'h1;
					divCnt     <= divTick ? 5'h0 : divCnt + 5'h1;
					if (divTick && tickCnt < CONV_TICKS[7:0])
						tickCnt <= tickCnt + 8'h1;
					if (finish) begin
						state <= ST_IDLE;
						resHi <= resFull;
						resLo <= sampleData[7:0];
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	property p_sw_start;
		swStart && !busy |=> busy;
	endproperty
	a_sw_start: assert property (p_sw_start) else $error("software start missed");

	property p_any_start;
		!busy && trigVec[startSrc] |=> busy ##1 busy;
	endproperty
	a_any_start: assert property (p_any_start) else $error("selected start missed");

	property p_ext_edge;
		!busy && startSrc == SRC_EXT && extSync2 && !extPrev |=> busy;
	endproperty
	a_ext_edge: assert property (p_ext_edge) else $error("pin edge start missed");

	property p_split_timer;
		!busy && startSrc == SRC_T3 && timer8BitMode[3] && timerOvfLow[3] |=> busy;
	endproperty
	a_split_timer: assert property (p_split_timer) else $error("timer 3 low start missed");

	property p_done_fall;
		$fell(busy) |-> doneFlag && (convIrq == irqEn);
	endproperty
	a_done_fall: assert property (p_done_fall) else $error("done not set on busy fall");

	property p_min_time;
		$fell(busy) |-> convCycles >= 16'(`ACSC_MIN_CONV_CYC);
	endproperty
	a_min_time: assert property (p_min_time) else $error("conversion too short");

	property p_ignore;
		busy && !finish |=> busy;
	endproperty
	a_ignore: assert property (p_ignore) else $error("conversion disturbed");

	property p_result;
		$fell(busy) |-> resLo == $past(sampleData[7:0]);
	endproperty
	a_result: assert property (p_result) else $error("result not captured");

	property p_lth;
		wrLth |=> lthReg == $past(sfrWrData);
	endproperty
	a_lth: assert property (p_lth) else $error("threshold high byte not stored");

	c_sw_conv: cover property (swStart ##1 busy ##[1:1000] !busy);
	c_ext_conv: cover property (startSrc == SRC_EXT && extEdge && !busy);
	c_ignored: cover property (busy && trigVec[startSrc]);

endmodule
`default_nettype wire

// ===== tb/acsc_timer_model.sv
// Purpose: Timer overflow source facing the converter start control
// Assumes: Bench requests each overflow half through loReq and hiReq
// Notes:   Each request leaves as a one-cycle pulse, like a timer carry
`timescale 1ns/1ps
`default_nettype none

module acsc_timer_model (
	input  wire logic       core_clk,
	input  wire logic [5:0] loReq,
	input  wire logic [5:0] hiReq,
	output logic      [5:0] timerOvfLow,
	output logic      [5:0] timerOvfHigh
);
	// ==========================================================
	// Overflow pulses
	// Registered so pulses leave on the edge, never mid-cycle
	always_ff @(posedge core_clk) begin
		timerOvfLow  <= loReq;
		timerOvfHigh <= hiReq;
	end
endmodule

`default_nettype wire

// ===== tb/tb_adc_conversion_start_control.sv
// Purpose: Self-checking bench of the converter start control
// Assumes: Divider written to zero after the slow conversion
// Notes:   CONV_TICKS of 2 keeps each divider-zero conversion near 50 cycles
`timescale 1ns/1ps
`default_nettype none
`include "acsc_params.svh"

module tb_adc_conversion_start_control
	import acsc_pkg::*;
;
	logic       core_clk, convIrq;
	logic       rst_b = 1'b0, sfrWrEn = 1'b0, extConvStart = 1'b0;
	logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00, sfrRdData;
	logic [5:0] loReq = '0, hiReq = '0, timerOvfLow, timerOvfHigh;
	logic [5:0] timer8BitMode = '0;
	logic [9:0] sampleData = 10'h2B6;
	logic       use8;
	int         n_fail = 0, checked = 0, cyc = 0, n, t;
	int         tix[8] = '{0, 0, 2, 1, 0, 3, 4, 5};

	acsc_start_ctrl #(.CONV_TICKS(2)) u_dut (.core_clk(core_clk), .rst_b(rst_b),
		.sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdData(sfrRdData),
		.timerOvfLow(timerOvfLow), .timerOvfHigh(timerOvfHigh), .timer8BitMode(timer8BitMode),
		.extConvStart(extConvStart), .sampleData(sampleData), .convIrq(convIrq));

	acsc_timer_model u_tmr (.core_clk(core_clk), .loReq(loReq), .hiReq(hiReq),
		.timerOvfLow(timerOvfLow), .timerOvfHigh(timerOvfHigh));

	// ==========================================================
	// Clock and watchdog
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			stop_test();
		end
	end

	// ==========================================================
	// Access tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// Strobe drops for a full cycle so back-to-back writes never double-drive it
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfrAddr   <= a;
		sfrWrData <= d;
		sfrWrEn   <= 1'b1;
		@(posedge core_clk);
		sfrWrEn <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		sfrAddr <= a;
		@(posedge core_clk);
		// Read data is taken mid-cycle, well clear of the edge that launches it
		@(negedge core_clk);
		chk(sfrRdData, exp, what);
		@(posedge core_clk);
	endtask

	// Polls the done flag, never the busy bit; gives up at 100 cycles
	task automatic wait_done(output int k);
		k = 0;
		@(negedge core_clk);
		while (sfrRdData[`ACSC_CTL_DONE] !== 1'b1 && k < 100) begin
			@(negedge core_clk);
			k++;
		end
		@(posedge core_clk);
	endtask

	task automatic fire(input int i, input logic lo, input logic hi);
		loReq[i] <= lo;
		hiReq[i] <= hi;
		@(posedge core_clk);
		loReq <= '0;
		hiReq <= '0;
		@(posedge core_clk);
	endtask

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ==========================================================
	// Test sequence
	initial begin
		repeat (4) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		rd(`ACSC_ADDR_LTH, 8'h00, "lth reset");
		rd(`ACSC_ADDR_LTL, 8'h00, "ltl reset");
		rd(`ACSC_ADDR_CFG, 8'hF8, "cfg reset");
		rd(8'h00, 8'h00, "unmapped read");
		wr(`ACSC_ADDR_LTH, 8'hA5);
		wr(`ACSC_ADDR_LTL, 8'h5A);
		rd(`ACSC_ADDR_LTH, 8'hA5, "lth rw");
		rd(`ACSC_ADDR_LTL, 8'h5A, "ltl rw");
		wr(`ACSC_ADDR_CTL, 8'h10);
		rd(`ACSC_ADDR_CTL, 8'h10, "busy set");
		wait_done(n);
		chk(8'(n > 56 && n < 100), 8'h01, "slow divider");
		chk({7'h0, convIrq}, 8'h00, "masked irq");
		rd(`ACSC_ADDR_CTL, 8'h20, "done, not busy");
		rd(`ACSC_ADDR_RES_LO, 8'hB6, "result low");
		rd(`ACSC_ADDR_RES_HI, 8'h02, "result high");
		sampleData <= 10'h14D;
		wr(`ACSC_ADDR_CFG, 8'h00);
		wr(`ACSC_ADDR_CTL, 8'h18);
		rd(`ACSC_ADDR_CTL, 8'h18, "busy again");
		wr(`ACSC_ADDR_CTL, 8'h18);
		wait_done(n);
		// A restart by the second busy write would land completion four cycles later
		chk(8'(n >= 44 && n <= 48), 8'h01, "fast conversion");
		chk({7'h0, convIrq}, 8'h01, "sw irq");
		rd(`ACSC_ADDR_RES_LO, 8'h4D, "second result low");
		rd(`ACSC_ADDR_RES_HI, 8'h01, "second result high");
		for (int s = 1; s < 8; s++) begin
			if (s == SRC_EXT)
				continue;
			t = tix[s];
			use8 = t >= 2 && s[0];
			timer8BitMode <= {6{s[0]}};
			wr(`ACSC_ADDR_CTL, 8'h08 | 8'(s));
			rd(`ACSC_ADDR_CTL, 8'h08 | 8'(s), "source set");
			fire(t, !use8, use8);
			fire((t + 1) % 6, 1'b1, 1'b1);
			wait_done(n);
			chk(8'(n), 8'h64, "no start");
			fire(t, 1'b1, 1'b1);
			wait_done(n);
			chk({7'h0, convIrq}, 8'h01, "timer irq");
		end
		wr(`ACSC_ADDR_CTL, 8'h0C);
		rd(`ACSC_ADDR_CTL, 8'h0C, "pin source");
		// Nothing but the bench drives the start pin while it serves as trigger
		extConvStart <= 1'b1;
		wait_done(n);
		chk({7'h0, convIrq}, 8'h01, "pin irq");
		stop_test();
	end
endmodule

`default_nettype wire
